// ==== eia_pkg.sv ====
`default_nettype none
package eia_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam int          ARRAY_DEPTH   = 128;
  localparam logic [7:0]  KEY_FIRST     = 8'hc9;
  localparam logic [7:0]  KEY_SECOND    = 8'h3a;
  localparam logic [7:0]  KEY_THIRD     = 8'hd3;
  localparam logic        LOCK_RESET    = 1'b1;
  localparam logic        OVERTIME_RESET = 1'b0;
  localparam int          TO_SEL_W      = 3;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int          PROG_NS       = 500000;
  localparam int          PROG_CYCLES   = PROG_NS / CLK_PERIOD_NS;
  // core-side register map, word offsets in bytes
  localparam logic [7:0]  REG_CMD       = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h0c;
  localparam logic [7:0]  REG_CTRL      = 8'h10;
  localparam int          CMD_OP_LSB    = 0;
  localparam int          CMD_ARG_LSB   = 8;
  localparam int          ST_BUSY       = 0;
  localparam int          ST_LOCK       = 1;
  localparam int          ST_OVERTIME   = 2;
  localparam int          ST_DEV_BUSY   = 3;
  localparam int          ST_WORK_LSB   = 8;
  localparam int          IRQ_CMD_DONE  = 0;
  localparam int          IRQ_WR_DONE   = 1;
  localparam int          CTRL_WDIE     = 0;
  localparam int          CTRL_GIE      = 1;
  typedef enum logic [2:0] {
    OP_ADDR_RD, OP_ADDR_WR, OP_DATA_RD, OP_DATA_WR,
    OP_ARRAY_RD, OP_ARRAY_WR, OP_KEY_WR
  } eia_op_e;
endpackage : eia_pkg
`default_nettype wire

// ==== eia_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface eia_if;
  logic            cmd_valid;
  eia_pkg::eia_op_e cmd_op;
  logic [7:0]      cmd_operand;
  logic            cmd_ready;
  logic            rsp_valid;
  logic [7:0]      rsp_data;
  logic            write_lock_flag;
  logic            write_overtime_flag;
  logic            write_done_irq_flag;
  logic            write_done_irq;
  logic            write_done_irq_enable;
  logic            global_irq_enable;
  logic            irq_flag_clear;
  modport dev  (input cmd_valid, cmd_op, cmd_operand, write_done_irq_enable,
                global_irq_enable, irq_flag_clear,
                output cmd_ready, rsp_valid, rsp_data, write_lock_flag,
                write_overtime_flag, write_done_irq_flag, write_done_irq);
  modport core (output cmd_valid, cmd_op, cmd_operand, write_done_irq_enable,
                global_irq_enable, irq_flag_clear,
                input cmd_ready, rsp_valid, rsp_data, write_lock_flag,
                write_overtime_flag, write_done_irq_flag, write_done_irq);
endinterface : eia_if
`default_nettype wire

// ==== eia_tick.sv ====
`timescale 1ns/10ps
`default_nettype none
module eia_tick #(
  parameter int DIV = eia_pkg::MS_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enable,
  output var  logic tick
);
  logic [$clog2(DIV+1)-1:0] count;

  // restarts whenever disabled so every period is whole
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!enable) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == ($bits(count))'(DIV - 1)) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule : eia_tick
`default_nettype wire

// ==== eia_dev.sv ====
// Summary of operation
// R1: 128-byte array reached only through holders
// R2: address holder read and write commands
// R3: data holder read and write commands
// R4: array read loads data holder, work undefined
// R5: array write programs data holder at address
// R6: program writes C9, 3A, D3 keys first
// R7: full key sequence releases write protection
// R8: completed write raises gated done interrupt
// R9: program keeps interrupts off during writes
// R10: program enables watchdog or write time-out
// R11: 3-bit time-out select loaded by write
// R12: codes map to 1,2,4,8,16,32,16,32 ms
// R13: program sets time-out before any write
// R14: program picks 2ms below 2.7V, else 1ms
// R15: address holder 8-bit, selects array location
// R16: key holder write-only, loaded by key command
// R17: read-only lock flag, 1 while locked
// R18: read-only overtime flag when time-out enabled
// R19: locked array write changes nothing, no interrupt; the code still loads the time-out select field
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module eia_dev #(
  parameter int MS_CYCLES   = eia_pkg::MS_CYCLES,
  parameter int PROG_CYCLES = eia_pkg::PROG_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic timeout_en,
  eia_if.dev        link
);
  typedef enum logic [1:0] {
    KEY_NONE, KEY_ONE, KEY_TWO
  } eia_key_e;

  logic [7:0]  array_mem [eia_pkg::ARRAY_DEPTH];
  logic [7:0]  array_address_holder;
  logic [7:0]  array_data_holder;
  logic [7:0]  unlock_key_holder;
  logic [2:0]  timeout_select_field;
  eia_key_e    key_stage;
  logic        key_hit;
  logic        busy;
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_count;
  logic [5:0]  ms_count;
  logic [5:0]  ms_limit;
  logic        ms_tick;
  logic        take;
  logic        prog_done;
  logic        overtime;
  logic        write_start;

  assign take        = link.cmd_valid && link.cmd_ready;
  assign write_start = take && link.cmd_op == eia_pkg::OP_ARRAY_WR && !link.write_lock_flag;
  assign prog_done   = busy && prog_count == ($bits(prog_count))'(PROG_CYCLES - 1);
  assign overtime    = busy && timeout_en && ms_count >= ms_limit;

  // 110 and 111 fold back onto the 16 ms and 32 ms periods
  always_comb begin
    case (timeout_select_field) // R12
      3'h0:    ms_limit = 6'h01;
      3'h1:    ms_limit = 6'h02;
      3'h2:    ms_limit = 6'h04;
      3'h3:    ms_limit = 6'h08;
      3'h4:    ms_limit = 6'h10;
      3'h6:    ms_limit = 6'h10;
      default: ms_limit = 6'h20;
    endcase
  end

  eia_tick #(
    .DIV     (MS_CYCLES)
  ) u_ms_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (busy),
    .tick    (ms_tick)
  );

  // holders have no reset: their content is undefined until loaded
  always_ff @(posedge hclk) begin
    if (take) begin
      case (link.cmd_op)
        eia_pkg::OP_ADDR_WR:  array_address_holder <= link.cmd_operand; // R2 R15
        eia_pkg::OP_DATA_WR:  array_data_holder <= link.cmd_operand; // R3
        eia_pkg::OP_ARRAY_RD: array_data_holder <= array_mem[array_address_holder[6:0]]; // R4 R1
        eia_pkg::OP_KEY_WR:   unlock_key_holder <= link.cmd_operand; // R16
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk) begin
    if (take && link.cmd_op == eia_pkg::OP_ARRAY_WR) begin
      timeout_select_field <= link.cmd_operand[2:0]; // R11
    end
  end

  // only the upper half of the address space aliases; bit 7 is ignored
  always_ff @(posedge hclk) begin
    if (prog_done && !overtime) begin
      array_mem[array_address_holder[6:0]] <= array_data_holder; // R5 R1 R15
    end
  end

  // the byte this stage is waiting for
  always_comb begin
    case (key_stage)
      KEY_NONE: key_hit = link.cmd_operand == eia_pkg::KEY_FIRST;
      KEY_ONE:  key_hit = link.cmd_operand == eia_pkg::KEY_SECOND;
      KEY_TWO:  key_hit = link.cmd_operand == eia_pkg::KEY_THIRD;
      default:  key_hit = 1'b0;
    endcase
  end

  // a bad byte restarts the sequence, unless it is itself a first key
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_stage            <= KEY_NONE;
      link.write_lock_flag <= eia_pkg::LOCK_RESET;
    end else if (take && link.cmd_op == eia_pkg::OP_KEY_WR) begin
      if (key_hit) begin
        case (key_stage)
          KEY_NONE: key_stage <= KEY_ONE;
          KEY_ONE:  key_stage <= KEY_TWO;
          default: begin
            key_stage            <= KEY_NONE;
            link.write_lock_flag <= 1'b0; // R7 R6 R17
          end
        endcase
      end else begin
        key_stage            <= (link.cmd_operand == eia_pkg::KEY_FIRST) ? KEY_ONE : KEY_NONE;
        link.write_lock_flag <= 1'b1;
      end
    end else if (take) begin
      // any other command breaks the back-to-back key sequence
      key_stage <= KEY_NONE;
      if (link.cmd_op == eia_pkg::OP_ARRAY_WR) begin
        link.write_lock_flag <= 1'b1; // R17
      end
    end
  end

  // locked writes never start, so array and interrupt stay untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy       <= 1'b0;
      prog_count <= '0;
      ms_count   <= 6'h00;
    end else if (write_start) begin // R19
      busy       <= 1'b1;
      prog_count <= '0;
      ms_count   <= 6'h00;
    end else if (busy) begin
      if (prog_done || overtime) begin
        busy <= 1'b0;
      end
      prog_count <= prog_count + 1'b1;
      if (ms_tick && ms_count != 6'h3f) begin
        ms_count <= ms_count + 6'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.write_overtime_flag <= eia_pkg::OVERTIME_RESET;
    end else if (write_start) begin
      link.write_overtime_flag <= 1'b0;
    end else if (overtime) begin
      link.write_overtime_flag <= 1'b1; // R18
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.write_done_irq_flag <= 1'b0;
    end else if (prog_done && !overtime) begin
      link.write_done_irq_flag <= 1'b1; // R8
    end else if (link.irq_flag_clear) begin
      link.write_done_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.write_done_irq <= 1'b0;
    end else begin
      link.write_done_irq <= (link.write_done_irq_flag || (prog_done && !overtime))
                             && link.write_done_irq_enable
                             && link.global_irq_enable; // R8
    end
  end

  // no new command while programming; drops on the same edge that takes the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.cmd_ready <= 1'b0;
    end else if (write_start) begin
      link.cmd_ready <= 1'b0;
    end else begin
      link.cmd_ready <= !busy || prog_done || overtime;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_data  <= 8'h00;
    end else begin
      link.rsp_valid <= take;
      if (take) begin
        case (link.cmd_op)
          eia_pkg::OP_ADDR_RD: link.rsp_data <= array_address_holder; // R2
          eia_pkg::OP_DATA_RD: link.rsp_data <= array_data_holder; // R3
          eia_pkg::OP_ARRAY_RD: link.rsp_data <= 8'h00; // R4
          default:             link.rsp_data <= link.cmd_operand;
        endcase
      end
    end
  end
endmodule : eia_dev
`default_nettype wire

// ==== eia_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module eia_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  output var  logic        irq,
  eia_if.core              link
);
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       busy;
  logic [7:0] work_register;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic       ctrl_wdie;
  logic       ctrl_gie;
  logic       wdone_q;
  logic       addr_ok;
  logic       cmd_wr;
  logic       stat_wr;

  assign addr_ok = hsel && htrans[1] && hready;
  assign cmd_wr  = wr_pend && wr_addr == eia_pkg::REG_CMD && !busy;
  assign stat_wr = wr_pend && wr_addr == eia_pkg::REG_IRQ_STAT;

  // zero wait states; reads are served from the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
      hrdata  <= 32'h0000_0000;
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          eia_pkg::REG_STATUS: begin
            hrdata[eia_pkg::ST_BUSY]                 <= busy;
            hrdata[eia_pkg::ST_LOCK]                 <= link.write_lock_flag; // R17
            hrdata[eia_pkg::ST_OVERTIME]             <= link.write_overtime_flag; // R18
            hrdata[eia_pkg::ST_DEV_BUSY]             <= !link.cmd_ready;
            hrdata[eia_pkg::ST_WORK_LSB +: 8]        <= work_register;
          end
          eia_pkg::REG_IRQ_STAT: hrdata[1:0] <= irq_stat;
          eia_pkg::REG_IRQ_MASK: hrdata[1:0] <= irq_mask;
          eia_pkg::REG_CTRL:     hrdata[1:0] <= {ctrl_gie, ctrl_wdie};
          default: ;
        endcase
      end
    end
  end

  // a command written while one is pending is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy             <= 1'b0;
      link.cmd_valid   <= 1'b0;
      link.cmd_op      <= eia_pkg::OP_ADDR_RD;
      link.cmd_operand <= 8'h00;
    end else if (cmd_wr) begin
      busy             <= 1'b1;
      link.cmd_valid   <= 1'b1;
      link.cmd_op      <= eia_pkg::eia_op_e'(hwdata[eia_pkg::CMD_OP_LSB +: 3]);
      link.cmd_operand <= hwdata[eia_pkg::CMD_ARG_LSB +: 8]; // R6 R11 R13
    end else begin
      if (link.cmd_valid && link.cmd_ready) begin
        link.cmd_valid <= 1'b0;
      end
      if (link.rsp_valid) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      work_register <= 8'h00;
    end else if (link.rsp_valid) begin
      work_register <= link.rsp_data; // R2 R3 R4
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_wdie <= 1'b0;
      ctrl_gie  <= 1'b0;
      irq_mask  <= 2'h0;
    end else if (wr_pend && wr_addr == eia_pkg::REG_CTRL) begin
      ctrl_wdie <= hwdata[eia_pkg::CTRL_WDIE];
      ctrl_gie  <= hwdata[eia_pkg::CTRL_GIE]; // R9
    end else if (wr_pend && wr_addr == eia_pkg::REG_IRQ_MASK) begin
      irq_mask <= hwdata[1:0];
    end
  end

  assign link.write_done_irq_enable = ctrl_wdie;
  assign link.global_irq_enable     = ctrl_gie;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.irq_flag_clear <= 1'b0;
    end else begin
      link.irq_flag_clear <= stat_wr && hwdata[eia_pkg::IRQ_WR_DONE];
    end
  end

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= 2'h0;
      wdone_q  <= 1'b0;
      irq      <= 1'b0;
    end else begin
      wdone_q <= link.write_done_irq;
      irq_stat[eia_pkg::IRQ_CMD_DONE] <= link.rsp_valid ||
        (irq_stat[eia_pkg::IRQ_CMD_DONE] && !(stat_wr && hwdata[eia_pkg::IRQ_CMD_DONE]));
      irq_stat[eia_pkg::IRQ_WR_DONE] <= (link.write_done_irq && !wdone_q) ||
        (irq_stat[eia_pkg::IRQ_WR_DONE] && !(stat_wr && hwdata[eia_pkg::IRQ_WR_DONE]));
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule : eia_host
`default_nettype wire

// ==== eia_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module eia_assertions (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             cmd_valid,
  input wire eia_pkg::eia_op_e cmd_op,
  input wire logic [7:0]       cmd_operand,
  input wire logic             cmd_ready,
  input wire logic             rsp_valid,
  input wire logic [7:0]       rsp_data,
  input wire logic             write_lock_flag,
  input wire logic             write_overtime_flag,
  input wire logic             write_done_irq_flag,
  input wire logic             write_done_irq,
  input wire logic             write_done_irq_enable,
  input wire logic             global_irq_enable,
  input wire logic             irq_flag_clear
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic key_last;
  logic wr_take;
  assign take     = cmd_valid && cmd_ready;
  assign key_last = take && cmd_op == eia_pkg::OP_KEY_WR && cmd_operand == eia_pkg::KEY_THIRD;
  assign wr_take  = take && cmd_op == eia_pkg::OP_ARRAY_WR;
  property p_rsp_cause;
    rsp_valid |-> $past(take);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("response without command");
  property p_data_echo;
    take && cmd_op == eia_pkg::OP_DATA_WR |=> rsp_valid && rsp_data == $past(cmd_operand);
  endproperty
  a_data_echo: assert property (p_data_echo) else $error("data holder load not echoed");
  property p_unlock;
    $fell(write_lock_flag) |-> $past(key_last) || $past(key_last, 2);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock without full key");
  property p_prog_busy;
    wr_take && !write_lock_flag |=> (!cmd_ready)[*8];
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("programming phase too short");
  property p_prog_end;
    $fell(cmd_ready) |-> ##[1:40] cmd_ready;
  endproperty
  a_prog_end: assert property (p_prog_end) else $error("programming never ends");
  property p_locked_write;
    wr_take && write_lock_flag |=> cmd_ready && write_lock_flag && !$rose(write_done_irq_flag);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write went ahead");
  property p_irq_gate;
    write_done_irq |-> $past(write_done_irq_enable && global_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");
  property p_flag_sticky;
    write_done_irq_flag && !irq_flag_clear |=> write_done_irq_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("done flag lost");
  property p_overtime;
    $rose(write_overtime_flag) |-> write_lock_flag && !$past(cmd_ready);
  endproperty
  a_overtime: assert property (p_overtime) else $error("overtime outside programming");
endmodule : eia_assertions
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        hclk;
  logic        hresetn;
  logic        timeout_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic [31:0] rd;
  int          errors;
  int          comparisons;
  int          cycles;
  eia_if link_if ();
  eia_dev #(.MS_CYCLES(10), .PROG_CYCLES(20)) eia_dev_inst (.hclk(hclk), .hresetn(hresetn),
    .timeout_en(timeout_en), .link(link_if));
  eia_host eia_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link_if));
  eia_assertions eia_assertions_inst (.hclk(hclk), .hresetn(hresetn),
    .cmd_valid(link_if.cmd_valid), .cmd_op(link_if.cmd_op), .cmd_operand(link_if.cmd_operand),
    .cmd_ready(link_if.cmd_ready), .rsp_valid(link_if.rsp_valid), .rsp_data(link_if.rsp_data),
    .write_lock_flag(link_if.write_lock_flag), .write_overtime_flag(link_if.write_overtime_flag),
    .write_done_irq_flag(link_if.write_done_irq_flag), .write_done_irq(link_if.write_done_irq),
    .write_done_irq_enable(link_if.write_done_irq_enable),
    .global_irq_enable(link_if.global_irq_enable), .irq_flag_clear(link_if.irq_flag_clear));
  always #5 hclk = ~hclk;
  task automatic report_and_stop;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // called just after a rising edge; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  // leaves the final STATUS word in rd
  task automatic cmd(input eia_pkg::eia_op_e op, input logic [7:0] v);
    ahb(1'b1, eia_pkg::REG_CMD, {16'h0, v, 5'h0, op});
    do ahb(1'b0, eia_pkg::REG_STATUS, 32'h0); while (rd[0] !== 1'b0 || rd[3] !== 1'b0);
  endtask : cmd
  task automatic unlock;
    cmd(eia_pkg::OP_KEY_WR, eia_pkg::KEY_FIRST);
    cmd(eia_pkg::OP_KEY_WR, eia_pkg::KEY_SECOND);
    cmd(eia_pkg::OP_KEY_WR, eia_pkg::KEY_THIRD);
  endtask : unlock
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic [7:0] code);
    cmd(eia_pkg::OP_ADDR_WR, a);
    cmd(eia_pkg::OP_DATA_WR, d);
    cmd(eia_pkg::OP_ARRAY_WR, code);
  endtask : put
  // scrubs the data holder first so a stale value cannot pass
  task automatic fetch(input logic [7:0] a, input logic [7:0] exp);
    cmd(eia_pkg::OP_ADDR_WR, a);
    cmd(eia_pkg::OP_DATA_WR, ~exp);
    cmd(eia_pkg::OP_ARRAY_RD, 8'h00);
    cmd(eia_pkg::OP_DATA_RD, 8'h00);
    chk(rd[15:8], exp);
  endtask : fetch
  task automatic t_holders;
    ahb(1'b0, eia_pkg::REG_STATUS, 32'h0);
    chk(rd[2:1], 2'b01);
    chk({hreadyout, hresp}, 2'b10);
    cmd(eia_pkg::OP_ADDR_WR, 8'h45);
    cmd(eia_pkg::OP_ADDR_RD, 8'h00);
    chk(rd[15:8], 8'h45);
    cmd(eia_pkg::OP_DATA_WR, 8'h23);
    cmd(eia_pkg::OP_DATA_RD, 8'h00);
    chk(rd[15:8], 8'h23);
    $display("test holders done");
  endtask : t_holders
  task automatic t_keys;
    cmd(eia_pkg::OP_KEY_WR, eia_pkg::KEY_FIRST);
    cmd(eia_pkg::OP_KEY_WR, eia_pkg::KEY_SECOND);
    cmd(eia_pkg::OP_KEY_WR, 8'h00);
    chk(rd[1], 1'b1);
    unlock();
    chk(rd[1], 1'b0);
    $display("test keys done");
  endtask : t_keys
  task automatic t_write;
    ahb(1'b1, eia_pkg::REG_CTRL, 32'h3);
    ahb(1'b1, eia_pkg::REG_IRQ_MASK, 32'h2);
    put(8'h10, 8'h5a, 8'h07);
    chk(rd[1], 1'b1);
    ahb(1'b0, eia_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[1:0], 2'b11);
    chk(irq, 1'b1);
    ahb(1'b1, eia_pkg::REG_IRQ_STAT, 32'h2);
    ahb(1'b0, eia_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[1:0], 2'b01);
    chk(irq, 1'b0);
    fetch(8'h10, 8'h5a);
    put(8'h10, 8'ha5, 8'h07);
    chk(irq, 1'b0);
    fetch(8'h10, 8'h5a);
    $display("test write done");
  endtask : t_write
  task automatic t_timeout;
    // interrupts off: completed writes must not reach the status bit
    ahb(1'b1, eia_pkg::REG_CTRL, 32'h0);
    timeout_en <= 1'b1;
    unlock();
    put(8'h10, 8'h77, 8'h00);
    chk(rd[2:1], 2'b11);
    fetch(8'h10, 8'h5a);
    for (int c = 2; c < 8; c++) begin
      unlock();
      put(8'h60 + 8'(c), 8'h30 + 8'(c), 8'(c));
      chk(rd[2], 1'b0);
    end
    for (int c = 2; c < 8; c++) fetch(8'h60 + 8'(c), 8'h30 + 8'(c));
    ahb(1'b0, eia_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[1], 1'b0);
    chk(irq, 1'b0);
    $display("test timeout done");
  endtask : t_timeout
  initial begin
    hclk       = 1'b0;
    hresetn    = 1'b0;
    timeout_en = 1'b0;
    hsel       = 1'b1;
    haddr      = 32'h0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0;
    errors     = 0;
    comparisons = 0;
    cycles     = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_holders();
    t_keys();
    t_write();
    t_timeout();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
